// File: spms_pkg.sv
// Purpose: shared constants for the serial master/slave port
// Assumes: control, prescaler and status bits reach the core as plain ports
// Notes: field positions are the bit numbers inside each byte or nibble port
package spms_pkg;

  // ------------------------------------------------------------
  // control byte fields
  // ------------------------------------------------------------
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_OUT_EN = 6;
  localparam int CTL_IRQ_SEL = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_IDLE = 3;
  localparam int CTL_PHASE = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ------------------------------------------------------------
  // prescaler nibble fields
  // ------------------------------------------------------------
  localparam int PRE_HALF = 3;
  localparam int PRE_VAL_HI = 2;
  localparam logic [3:0] PRE_RESET = 4'h0;

  // ------------------------------------------------------------
  // status byte fields
  // ------------------------------------------------------------
  localparam int STA_DONE = 7;
  localparam int STA_WRITE_COLLISION_FLAG = 6;
  localparam int STA_MODE_FAULT_FLAG = 4;

  // ------------------------------------------------------------
  // rate selection dividers and timing
  // ------------------------------------------------------------
  localparam logic [5:0] RATE_DIV_0 = 6'h02;
  localparam logic [5:0] RATE_DIV_1 = 6'h04;
  localparam logic [5:0] RATE_DIV_2 = 6'h10;
  localparam logic [5:0] RATE_DIV_3 = 6'h20;
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam int SYNC_PINS = 3;

endpackage : spms_pkg

// File: spms_pin_sync.sv
// Purpose: three-stage synchroniser for one pin input
// Assumes: input is asynchronous to SYS_CLK_I
// Notes: output changes only once the second and third stages agree
`timescale 1ns/10ps
`default_nettype none

module spms_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // pin and result
  input wire logic pin_i,
  output logic level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // shift chain, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_reg <= RESET_LEVEL;
      s2_reg <= RESET_LEVEL;
      s3_reg <= RESET_LEVEL;
      level_o <= RESET_LEVEL;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end

endmodule : spms_pin_sync
`default_nettype wire

// File: spms_core.sv
// Purpose: full-duplex serial port, master or slave, msb first
// Assumes: software strobes arrive on SYS_CLK_I, pins are asynchronous
// Notes: master input data is seen four cycles late; use slow rates
`timescale 1ns/10ps
`default_nettype none

// Contract
// - send and receive together on one clock
// - software picks master or slave role
// - msb first, data lines tied peer to peer
// - four master rate selections
// - 3-bit prescaler plus switchable halving
// - four pins: two data, clock, select
// - one shift register replaces sent byte
// - one flag marks each finished byte
// - master supplies clock, slave answers on it
// - both ends use same polarity and phase
// - master drives the clock pin itself
// - master bits hold only while select high
// - master drives out line, samples in line
// - flag data writes during a transfer
// - control, prescaler, status and data registers
// - done sets flag, irq needs select and enable
// - flag clears after status then data access
// - data writes ignored while flag set, unseen
// - select low as master faults to slave
module spms_core
  import spms_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // software strobes and write data
  input wire logic CTRL_WR_I,
  input wire logic [7:0] CTRL_WDATA_I,
  input wire logic PRESCALE_WR_I,
  input wire logic [3:0] PRESCALE_WDATA_I,
  input wire logic STATUS_ACC_I,
  input wire logic DATA_WR_I,
  input wire logic DATA_RD_I,
  input wire logic [7:0] DATA_WDATA_I,
  // software read values
  output logic [7:0] CTRL_O,
  output logic [3:0] PRESCALE_O,
  output logic [7:0] STATUS_O,
  output logic [7:0] RX_DATA_O,
  output logic IRQ_O,
  // serial pins
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_O,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE_O,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE_O,
  input wire logic SS_N_I
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [SYNC_PINS-1:0] pin_raw;
  logic [SYNC_PINS-1:0] pin_sync;
  assign pin_raw = {SS_N_I, MOSI_I, MISO_I};

  // one synchroniser per input pin, select idles high
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_PINS; gi++) begin : g_sync
      spms_pin_sync #(.RESET_LEVEL(gi == SYNC_PINS - 1)) u_sync (
        .clk_i(SYS_CLK_I),
        .reset_i(RESET_I),
        .pin_i(pin_raw[gi]),
        .level_o(pin_sync[gi])
      );
    end
  endgenerate

  logic sck_sync;
  spms_pin_sync #(.RESET_LEVEL(1'b0)) u_sck_sync (
    .clk_i(SYS_CLK_I),
    .reset_i(RESET_I),
    .pin_i(SCK_I),
    .level_o(sck_sync)
  );

  logic ss_n_s;
  logic mosi_s;
  logic miso_s;
  assign ss_n_s = pin_sync[2];
  assign mosi_s = pin_sync[1];
  assign miso_s = pin_sync[0];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic irq_en_reg;
  logic out_en_reg;
  logic irq_sel_reg;
  logic master_reg;
  logic idle_reg;
  logic phase_reg;
  logic [1:0] rate_reg;
  logic [3:0] pre_reg;
  logic done_reg;
  logic write_collision_flag_reg;
  logic mode_fault_flag_reg;
  logic done_seen_reg;
  logic write_collision_flag_seen_reg;
  logic mode_fault_flag_seen_reg;
  logic busy_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_reg;
  logic out_reg;
  logic sck_reg;
  logic sck_prev_reg;
  logic [3:0] edge_reg;
  logic [11:0] div_reg;

  // ------------------------------------------------------------
  // baud divider decode
  // ------------------------------------------------------------
  logic [5:0] rate_div;
  logic [11:0] full_div;
  logic [11:0] half_div;
  assign rate_div = (rate_reg == 2'd0) ? RATE_DIV_0 :
                    (rate_reg == 2'd1) ? RATE_DIV_1 :
                    (rate_reg == 2'd2) ? RATE_DIV_2 : RATE_DIV_3;
  assign full_div = 12'(rate_div * ({1'b0, pre_reg[PRE_VAL_HI:0]} + 4'd1)
                    * (pre_reg[PRE_HALF] ? 12'd2 : 12'd1));
  assign half_div = 12'(full_div >> 1);

  // ------------------------------------------------------------
  // edge decode, shared by master and slave
  // ------------------------------------------------------------
  logic slave_sel;
  logic m_tick;
  logic s_edge;
  logic edge_evt;
  logic edge_lead;
  logic sample_evt;
  logic drive_evt;
  logic done_evt;
  logic in_bit;
  logic [7:0] shift_in;
  assign slave_sel = !master_reg && out_en_reg && !ss_n_s;
  assign m_tick = master_reg && busy_reg && (div_reg == half_div - 12'd1);
  assign s_edge = slave_sel && (sck_sync != sck_prev_reg);
  assign edge_evt = m_tick || s_edge;
  assign edge_lead = !edge_reg[0];
  assign sample_evt = edge_evt && (edge_lead ^ phase_reg);
  assign drive_evt = edge_evt && !(edge_lead ^ phase_reg);
  assign done_evt = edge_evt && (edge_reg == LAST_EDGE);
  assign in_bit = master_reg ? miso_s : mosi_s;
  assign shift_in = {shift_reg[6:0], in_bit};

  // ------------------------------------------------------------
  // software access decode
  // ------------------------------------------------------------
  logic xfer_active;
  logic data_acc;
  logic wr_ok;
  logic wr_coll;
  logic fault;
  assign xfer_active = master_reg ? busy_reg : !ss_n_s;
  assign data_acc = DATA_WR_I || DATA_RD_I;
  assign wr_coll = DATA_WR_I && xfer_active;
  assign wr_ok = DATA_WR_I && !xfer_active && !(done_reg && !done_seen_reg)
                 && out_en_reg;
  assign fault = master_reg && !ss_n_s;

  // control and prescaler registers
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      {irq_en_reg, out_en_reg, irq_sel_reg, master_reg} <= CTL_RESET[7:4];
      {idle_reg, phase_reg, rate_reg} <= CTL_RESET[3:0];
      pre_reg <= PRE_RESET;
    end else begin
      if (CTRL_WR_I) begin
        irq_en_reg <= CTRL_WDATA_I[CTL_IRQ_EN];
        out_en_reg <= CTRL_WDATA_I[CTL_OUT_EN];
        irq_sel_reg <= CTRL_WDATA_I[CTL_IRQ_SEL];
        master_reg <= CTRL_WDATA_I[CTL_MASTER];
        idle_reg <= CTRL_WDATA_I[CTL_IDLE];
        phase_reg <= CTRL_WDATA_I[CTL_PHASE];
        rate_reg <= CTRL_WDATA_I[CTL_RATE_HI:CTL_RATE_LO];
      end
      if (fault) begin
        out_en_reg <= 1'b0;
        master_reg <= 1'b0;
      end
      if (PRESCALE_WR_I) begin
        pre_reg <= PRESCALE_WDATA_I;
      end
    end
  end

  // status flags, a hardware set wins over the software clear
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      {done_reg, done_seen_reg} <= 2'b00;
      {write_collision_flag_reg, write_collision_flag_seen_reg} <= 2'b00;
      {mode_fault_flag_reg, mode_fault_flag_seen_reg} <= 2'b00;
    end else begin
      if (STATUS_ACC_I && done_reg) done_seen_reg <= 1'b1;
      if (STATUS_ACC_I && write_collision_flag_reg) write_collision_flag_seen_reg <= 1'b1;
      if (STATUS_ACC_I && mode_fault_flag_reg) mode_fault_flag_seen_reg <= 1'b1;
      if (data_acc && done_seen_reg) begin
        done_reg <= 1'b0;
        done_seen_reg <= 1'b0;
      end
      if (data_acc && write_collision_flag_seen_reg) begin
        write_collision_flag_reg <= 1'b0;
        write_collision_flag_seen_reg <= 1'b0;
      end
      if (CTRL_WR_I && mode_fault_flag_seen_reg) begin
        mode_fault_flag_reg <= 1'b0;
        mode_fault_flag_seen_reg <= 1'b0;
      end
      if (done_evt) done_reg <= 1'b1;
      if (wr_coll) write_collision_flag_reg <= 1'b1;
      if (fault) mode_fault_flag_reg <= 1'b1;
    end
  end

  // master clock generator
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      div_reg <= 12'h000;
      sck_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      div_reg <= (m_tick || !busy_reg) ? 12'h000 : 12'(div_reg + 12'd1);
      if (!busy_reg || !master_reg) sck_reg <= idle_reg;
      else if (m_tick) sck_reg <= !sck_reg;
      if (wr_ok && master_reg) busy_reg <= 1'b1;
      else if (done_evt || !master_reg) busy_reg <= 1'b0;
    end
  end

  // shift register, edge counter and receive buffer
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      shift_reg <= 8'h00;
      rx_reg <= 8'h00;
      out_reg <= 1'b0;
      edge_reg <= 4'h0;
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= slave_sel ? sck_sync : idle_reg;
      if (wr_ok) begin
        shift_reg <= DATA_WDATA_I;
        out_reg <= DATA_WDATA_I[7];
        edge_reg <= 4'h0;
      end else begin
        if (!master_reg && ss_n_s) edge_reg <= 4'h0;
        else if (edge_evt) edge_reg <= 4'(edge_reg + 4'd1);
        if (sample_evt) shift_reg <= shift_in;
        if (drive_evt) out_reg <= shift_reg[7];
        if (done_evt) rx_reg <= sample_evt ? shift_in : shift_reg;
      end
    end
  end

  // pin drivers and read values
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      SCK_O <= 1'b0;
      {SCK_OE_O, MOSI_OE_O, MISO_OE_O} <= 3'b000;
      {MOSI_O, MISO_O, IRQ_O} <= 3'b000;
      CTRL_O <= CTL_RESET;
      PRESCALE_O <= PRE_RESET;
      STATUS_O <= 8'h00;
      RX_DATA_O <= 8'h00;
    end else begin
      SCK_O <= sck_reg;
      SCK_OE_O <= master_reg && out_en_reg;
      MOSI_OE_O <= master_reg && out_en_reg;
      MISO_OE_O <= slave_sel;
      MOSI_O <= out_reg;
      MISO_O <= out_reg;
      IRQ_O <= irq_en_reg && irq_sel_reg && (done_reg || mode_fault_flag_reg);
      CTRL_O <= {irq_en_reg, out_en_reg, irq_sel_reg, master_reg,
                 idle_reg, phase_reg, rate_reg};
      PRESCALE_O <= pre_reg;
      STATUS_O <= {done_reg, write_collision_flag_reg, 1'b0, mode_fault_flag_reg, 4'h0};
      RX_DATA_O <= rx_reg;
    end
  end

endmodule : spms_core
`default_nettype wire

// File: spms_sva.sv
// Purpose: port checks for the serial core
// Assumes: one clock, synchronous reset
// Notes: bound from the bench top file
`timescale 1ns/10ps
`default_nettype none

module spms_sva
  import spms_pkg::*;
(
  // clock, reset and strobes
  input wire logic SYS_CLK_I, RESET_I, CTRL_WR_I, DATA_WR_I, DATA_RD_I,
  // software values
  input wire logic [7:0] CTRL_WDATA_I, CTRL_O, STATUS_O,
  // irq and pins
  input wire logic IRQ_O, SCK_O, SCK_OE_O, MOSI_OE_O, MISO_OE_O, SS_N_I
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RESET_I);

  // enables follow the role
  a_oe_pair: assert property (MOSI_OE_O == SCK_OE_O &&
    SCK_OE_O == (CTRL_O[CTL_MASTER] && CTRL_O[CTL_OUT_EN])) else $error("enables differ");
  a_oe_excl: assert property (MISO_OE_O |-> !SCK_OE_O)
    else $error("both roles drive");
  // fault, irq, clock rest and flags
  a_mode_fault_flag_drop: assert property (SCK_OE_O && !SS_N_I |->
    ##[1:8] STATUS_O[STA_MODE_FAULT_FLAG] && !CTRL_O[CTL_MASTER] && !CTRL_O[CTL_OUT_EN])
    else $error("mode fault missed");
  a_irq_gate: assert property (IRQ_O |-> CTRL_O[CTL_IRQ_EN] && CTRL_O[CTL_IRQ_SEL]
    && (STATUS_O[STA_DONE] || STATUS_O[STA_MODE_FAULT_FLAG])) else $error("irq without cause");
  a_sck_rest: assert property ($rose(STATUS_O[STA_DONE]) && SCK_OE_O |->
    SCK_O == CTRL_O[CTL_IDLE]) else $error("clock not at rest");
  a_done_clear: assert property ($fell(STATUS_O[STA_DONE]) |->
    $past(DATA_RD_I, 2) || $past(DATA_WR_I, 2)) else $error("done cleared early");
  // write judged a cycle late, so the clock shown proves the byte was still running
  a_write_collision_flag_set: assert property ($past(DATA_WR_I) && SCK_OE_O &&
    SCK_O != CTRL_O[CTL_IDLE] |-> ##[1:3] STATUS_O[STA_WRITE_COLLISION_FLAG]) else $error("collision missed");
  a_ctrl_load: assert property (CTRL_WR_I |-> ##2 CTRL_O == $past(CTRL_WDATA_I, 2))
    else $error("control not loaded");
  // main scenarios reached
  c_done: cover property ($rose(STATUS_O[STA_DONE]));
  c_mode_fault_flag: cover property ($rose(STATUS_O[STA_MODE_FAULT_FLAG]));
  c_irq: cover property ($rose(IRQ_O));
endmodule : spms_sva
`default_nettype wire

// File: spms_peer.sv
// Purpose: behavioural serial slave facing the core
// Assumes: same idle level and phase as the core
// Notes: data line inverts its last bit once released
`timescale 1ns/10ps
`default_nettype none

module spms_peer (
  // serial pins
  input wire logic sck_i, mosi_i, cs_n_i,
  output logic miso_o,
  // mode and data
  input wire logic idle_i, phase_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] sh_o
);
  // load on select, no stale level after release
  initial miso_o = 1'b0;
  always @(cs_n_i) begin
    if (!cs_n_i) begin
      sh_o = tx_i;
      if (!phase_i) miso_o = tx_i[7];
    end else miso_o = ~miso_o;
  end
  // sample and shift on capture edge, drive msb out on the other
  always @(sck_i) begin
    if (!cs_n_i) begin
      if ((sck_i != idle_i) != phase_i) sh_o = {sh_o[6:0], mosi_i};
      else miso_o = sh_o[7];
    end
  end
endmodule : spms_peer
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for the serial core
// Assumes: pin levels come from whichever side enables its driver
// Notes: peer model answers in master runs, bench drives slave runs
`timescale 1ns/10ps
`default_nettype none

module tb
  import spms_pkg::*;
();
  localparam logic [7:0] MST = 8'(1 << CTL_OUT_EN | 1 << CTL_MASTER);
  localparam logic [7:0] IRQB = 8'(1 << CTL_IRQ_EN | 1 << CTL_IRQ_SEL);
  logic clk = 0, rst = 1, cwr = 0, pwr = 0, sacc = 0, dwr = 0, drd = 0;
  logic ss_n = 1, pcs_n = 1, m_sck = 0, m_mosi = 0, idle = 0, ph = 0;
  logic [7:0] cwd = 0, dwd = 0, ptx = 0, ctl_o, sta_o, rx_o, prx, sb, mb, got;
  logic [3:0] pwd = 0, pre_o;
  logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_miso;
  int n_mismatch = 0, total_checks = 0, cyc = 0, n, hp, pre, half, off;
  int dv[4] = '{2, 4, 16, 32};
  // pin levels
  wire logic sck = sck_oe ? sck_o : m_sck;
  wire logic mosi = mosi_oe ? mosi_o : m_mosi;
  wire logic miso = miso_oe ? miso_o : p_miso;

  spms_core i_dut (
    .SYS_CLK_I(clk), .RESET_I(rst), .CTRL_WR_I(cwr), .CTRL_WDATA_I(cwd),
    .PRESCALE_WR_I(pwr), .PRESCALE_WDATA_I(pwd), .STATUS_ACC_I(sacc), .DATA_WR_I(dwr),
    .DATA_RD_I(drd), .DATA_WDATA_I(dwd), .CTRL_O(ctl_o), .PRESCALE_O(pre_o),
    .STATUS_O(sta_o), .RX_DATA_O(rx_o), .IRQ_O(irq), .SCK_I(sck), .SCK_O(sck_o),
    .SCK_OE_O(sck_oe), .MOSI_I(mosi), .MOSI_O(mosi_o), .MOSI_OE_O(mosi_oe),
    .MISO_I(miso), .MISO_O(miso_o), .MISO_OE_O(miso_oe), .SS_N_I(ss_n)
  );
  spms_peer i_peer (.sck_i(sck), .mosi_i(mosi), .cs_n_i(pcs_n), .miso_o(p_miso),
    .idle_i(idle), .phase_i(ph), .tx_i(ptx), .sh_o(prx));

  // clock and hang guard
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask : wt
  task automatic pulse(ref logic s);
    s = 1;
    wt(1);
    s = 0;
  endtask : pulse
  task automatic wchg(output int k);
    logic t;
    t = sck_o;
    k = 0;
    while (sck_o === t && k < 9000) begin
      wt(1);
      k++;
    end
  endtask : wchg
  task automatic cfg(input logic [7:0] c, input logic [3:0] p);
    cwd = c;
    pwd = p;
    pwr = 1;
    pulse(cwr);
    pwr = 0;
    wt(2);
    chk("ctrl", 16'(c), 16'(ctl_o));
    chk("prescale", 16'(p), 16'(pre_o));
  endtask : cfg
  // one master byte with collision, ignored write and clearing
  task automatic xfer(input logic [7:0] tx, input logic [7:0] pt, input logic ie);
    ptx = pt;
    pcs_n = 0;
    wt(4);
    dwd = tx;
    pulse(dwr);
    wchg(n);
    wchg(n);
    chk("half period", 16'(hp), 16'(n));
    wchg(n);
    dwd = ~tx;
    pulse(dwr);
    n = 0;
    while (sta_o[STA_DONE] !== 1'b1 && n < 9000) begin
      wt(1);
      n++;
    end
    chk("rx buffer", 16'(pt), 16'(rx_o));
    chk("peer rx", 16'(tx), 16'(prx));
    chk("status", 16'h00c0, 16'(sta_o));
    chk("irq", 16'(ie), 16'(irq));
    chk("sck rest", 16'(idle), 16'(sck_o));
    pulse(dwr);
    wt(hp + 4);
    chk("held rest", 16'(idle), 16'(sck_o));
    pulse(sacc);
    pulse(drd);
    wt(2);
    chk("cleared", 16'h0000, 16'(sta_o));
    pcs_n = 1;
  endtask : xfer
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // reset, four master rates, mode fault, slave byte
  initial begin
    void'($urandom(45));
    wt(20);
    rst = 0;
    wt(2);
    chk("ctrl reset", 16'(CTL_RESET), 16'(ctl_o));
    // every idle level and phase pair once, from a random start
    off = $urandom % 4;
    for (int r = 0; r < 4; r++) begin
      {idle, ph} = 2'(r + off);
      half = $urandom % 2;
      pre = (r == 0) ? 7 : 3 + $urandom % 5;
      hp = dv[r] * (pre + 1) * (half + 1) / 2;
      cfg(MST | (r[0] ? IRQB : 8'h00) | {4'h0, idle, ph, 2'(r)}, {1'(half), 3'(pre)});
      xfer(8'($urandom), 8'($urandom), r[0]);
    end
    cfg(MST | IRQB, 4'h0);
    ss_n = 0;
    wt(10);
    chk("fault status", 16'h0010, 16'(sta_o));
    chk("fault ctrl", 16'(IRQB), 16'(ctl_o));
    chk("fault irq", 16'h0001, 16'(irq));
    ss_n = 1;
    pulse(sacc);
    cfg(8'h00, 4'h0);
    chk("fault clear", 16'h0000, 16'(sta_o));
    idle = 1'($urandom);
    ph = 1'($urandom);
    m_sck = idle;
    cfg(8'(1 << CTL_OUT_EN) | {4'h0, idle, ph, 2'b00}, 4'h0);
    sb = 8'($urandom);
    mb = 8'($urandom);
    dwd = sb;
    pulse(dwr);
    ss_n = 0;
    for (int i = 7; i >= 0; i--) begin
      m_mosi = mb[i];
      wt(8);
      if (!ph) got = {got[6:0], miso};
      m_sck = ~idle;
      wt(8);
      if (ph) got = {got[6:0], miso};
      m_sck = idle;
      wt(8);
    end
    wt(8);
    chk("slave tx", 16'(sb), 16'(got));
    chk("slave rx", 16'(mb), 16'(rx_o));
    chk("slave status", 16'h0080, 16'(sta_o));
    stop_test();
  end
endmodule : tb

bind spms_core spms_sva i_sva (.SYS_CLK_I, .RESET_I, .CTRL_WR_I, .DATA_WR_I, .DATA_RD_I,
  .CTRL_WDATA_I, .CTRL_O, .STATUS_O, .IRQ_O, .SCK_O, .SCK_OE_O, .MOSI_OE_O, .MISO_OE_O,
  .SS_N_I);
`default_nettype wire
